// file: pkg/sdev_pkg.sv
// Purpose: Constants and carrier types of the card event status flag bank
// Assumes: 32-bit Avalon-MM slave with byte addresses, one word per register
// Notes: Flag positions follow the status word layout; bit 8 and bits 31-13 read zero
package sdev_pkg;
  localparam logic [7:0]  ADDR_CTL      = 8'h00;
  localparam logic [7:0]  ADDR_STAT     = 8'h08;
  localparam logic [7:0]  ADDR_MASK     = 8'h0c;
  localparam logic [7:0]  ADDR_LEN      = 8'h10;
  localparam logic [7:0]  ADDR_RXD      = 8'h28;
  localparam logic [7:0]  ADDR_TXD      = 8'h2c;
  localparam logic [7:0]  ADDR_CMD      = 8'h30;

  localparam int          CTL_DPRST_BIT = 0;
  localparam int          CTL_EDGE_LSB  = 6;
  localparam logic        CTL_DPRST_RST = 1'b0;
  localparam logic [1:0]  CTL_EDGE_RST  = 2'h0;

  localparam int          CMD_XFER_BIT  = 0;
  localparam int          CMD_BSY_BIT   = 1;
  localparam int          CMD_DATA_CLEAR_ON_COMMAND_BIT  = 2;
  localparam int          CMD_W         = 3;

  localparam int          FLAGS_W       = 13;
  localparam int          FLG_TRN       = 12;
  localparam int          FLG_EDGE      = 11;
  localparam int          FLG_RX        = 10;
  localparam int          FLG_TX        = 9;
  localparam int          FLG_RCRC      = 7;
  localparam int          FLG_DCRC      = 6;
  localparam int          FLG_WCRC      = 5;
  localparam int          FLG_RTO       = 4;
  localparam int          FLG_DTO       = 3;
  localparam int          FLG_RSP       = 2;
  localparam int          FLG_BSY       = 1;
  localparam int          FLG_DAT       = 0;
  localparam logic [12:0] FLAGS_RST     = 13'h0200;
  localparam logic [12:0] FLAGS_IMPL    = 13'h1eff;
  localparam logic [12:0] FLAGS_COR     = 13'h18ff;
  localparam logic [12:0] MASK_RST      = 13'h0000;

  localparam logic [7:0]  BUSY_WAIT_CLKS = 8'h40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_HOLD = 2'b11,
    ST_PROG = 2'b10
  } sdev_dstate_t;

  typedef struct packed {
    logic rsp_ok;
    logic no_rsp_sent;
    logic cmd_end;
    logic rsp_crc;
    logic rd_crc;
    logic wr_crc;
    logic rsp_to;
    logic rd_to;
    logic byte_moved;
    logic crc_prog_done;
    logic rx_valid;
    logic tx_load;
    logic tx_sent;
  } sdev_evt_t;

  typedef struct packed {
    logic active;
    logic pause;
    logic in_reset;
    logic busy_watch;
  } sdev_dp_t;
endpackage

// file: verilog/sdev_sync.sv
`timescale 1ns/1ps
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to i_mclk
// Notes: Only the second stage leaves the module
module sdev_sync #(
  parameter int W = 3
) (
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sdev_sync_st_t;

  sdev_sync_st_t q;
  sdev_sync_st_t d;

  always_comb begin
    d      = q;
    d.meta = i_async;
    d.sync = q.meta;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.sync;
endmodule

// file: verilog/sdev_status.sv
`timescale 1ns/1ps
// Purpose: Event and status flag bank of a memory card host controller
// Assumes: Event strobes arrive on i_mclk; card clock and DAT pins are asynchronous
// Notes: Every access takes one wait cycle; read data is latched before the answer
module sdev_status #(
  parameter int         LEN_W     = 16,
  parameter logic [7:0] BUSY_WAIT = sdev_pkg::BUSY_WAIT_CLKS
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_srst,
  input  wire logic [7:0]                 i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic      [31:0]                o_avs_readdata,
  output logic                            o_avs_waitrequest,
  input  wire logic                       i_card_clk,
  input  wire logic                       i_dat3_pin,
  input  wire logic                       i_dat0_pin,
  input  wire sdev_pkg::sdev_evt_t        i_evt,
  input  wire logic [31:0]                i_rx_word,
  output logic      [31:0]                o_tx_word,
  output logic                            o_cmd_start,
  output logic      [sdev_pkg::CMD_W-1:0] o_cmd_bits,
  output sdev_pkg::sdev_dp_t              o_dp,
  output logic      [31:0]                o_status,
  output logic                            o_irq_req
);
  typedef struct packed {
    sdev_pkg::sdev_dstate_t         st;
    logic [sdev_pkg::FLAGS_W-1:0]   flags;
    logic [sdev_pkg::FLAGS_W-1:0]   mask;
    logic                           dp_rst;
    logic [1:0]                     edge_sel;
    logic [LEN_W-1:0]               len;
    logic [LEN_W-1:0]               cnt;
    logic [31:0]                    rxd;
    logic [31:0]                    txd;
    logic [31:0]                    rdata;
    logic                           ack;
    logic [sdev_pkg::CMD_W-1:0]     cmdw;
    logic                           cmd_start;
    logic                           hold_bsy;
    logic                           bexp;
    logic                           bw;
    logic                           bseen;
    logic [7:0]                     bcnt;
    logic                           prev_clk;
    logic                           prev_dat3;
    logic                           irq;
  } sdev_st_t;

  sdev_st_t                     q;
  sdev_st_t                     d;
  logic [2:0]                   pin_s;
  logic                         req;
  logic                         wr_fin;
  logic                         rd_fin;
  logic                         cmd_wr;
  logic                         data_clear_on_command;
  logic                         clk_rise;
  logic [31:0]                  w;
  logic [sdev_pkg::FLAGS_W-1:0] set;
  logic [sdev_pkg::FLAGS_W-1:0] clr;

  // Byte lanes of a write replace only the enabled bytes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctl_word(input logic       rst,
                                           input logic [1:0] sel);
    logic [31:0] r;
    r = '0;
    r[sdev_pkg::CTL_DPRST_BIT] = rst;
    r[sdev_pkg::CTL_EDGE_LSB +: 2] = sel;
    return r;
  endfunction

  // Pin order: card clock, DAT3, DAT0
  sdev_sync #(
    .W (3)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_async ({i_dat0_pin, i_dat3_pin, i_card_clk}),
    .o_sync  (pin_s)
  );

  always_comb begin
    d           = q;
    w           = '0;
    set         = '0;
    clr         = '0;
    req         = i_avs_read | i_avs_write;
    wr_fin      = i_avs_write & q.ack;
    rd_fin      = i_avs_read & q.ack;
    cmd_wr      = wr_fin & (i_avs_address == sdev_pkg::ADDR_CMD);
    data_clear_on_command        = cmd_wr & i_avs_byteenable[0] & i_avs_writedata[sdev_pkg::CMD_DATA_CLEAR_ON_COMMAND_BIT];
    clk_rise    = pin_s[0] & ~q.prev_clk;
    d.ack       = req & ~q.ack;
    d.prev_clk  = pin_s[0];
    d.prev_dat3 = pin_s[1];
    d.cmd_start = 1'b0;

    // Unmapped addresses read zero; reserved bits are never stored
    if (i_avs_read & ~q.ack) begin
      case (i_avs_address)
        sdev_pkg::ADDR_CTL:  d.rdata = ctl_word(q.dp_rst, q.edge_sel);
        sdev_pkg::ADDR_STAT: d.rdata = {19'h0, q.flags};
        sdev_pkg::ADDR_MASK: d.rdata = {19'h0, q.mask};
        sdev_pkg::ADDR_LEN:  d.rdata = 32'(q.len);
        sdev_pkg::ADDR_RXD:  d.rdata = q.rxd;
        sdev_pkg::ADDR_TXD:  d.rdata = q.txd;
        sdev_pkg::ADDR_CMD:  d.rdata = 32'(q.cmdw);
        default:             d.rdata = '0;
      endcase
    end

    if (wr_fin) begin
      case (i_avs_address)
        sdev_pkg::ADDR_CTL: begin
          w          = lane_merge(ctl_word(q.dp_rst, q.edge_sel), i_avs_writedata,
                                  i_avs_byteenable);
          d.dp_rst   = w[sdev_pkg::CTL_DPRST_BIT];
          d.edge_sel = w[sdev_pkg::CTL_EDGE_LSB +: 2];
        end
        sdev_pkg::ADDR_MASK: begin
          w      = lane_merge({19'h0, q.mask}, i_avs_writedata, i_avs_byteenable);
          d.mask = w[sdev_pkg::FLAGS_W-1:0] & sdev_pkg::FLAGS_IMPL;
        end
        sdev_pkg::ADDR_LEN: begin
          w     = lane_merge(32'(q.len), i_avs_writedata, i_avs_byteenable);
          d.len = w[LEN_W-1:0];
        end
        sdev_pkg::ADDR_TXD: begin
          d.txd = lane_merge(q.txd, i_avs_writedata, i_avs_byteenable);
        end
        sdev_pkg::ADDR_CMD: begin
          w      = lane_merge(32'(q.cmdw), i_avs_writedata, i_avs_byteenable);
          d.cmdw = w[sdev_pkg::CMD_W-1:0];
        end
        default: begin
          w = '0;
        end
      endcase
    end

    // Command path never waits on the data path
    if (cmd_wr) begin
      d.cmd_start = 1'b1;
      d.bexp      = w[sdev_pkg::CMD_BSY_BIT];
    end

    unique case (q.st)
      sdev_pkg::ST_IDLE: begin
        if (cmd_wr && w[sdev_pkg::CMD_XFER_BIT]) begin
          if (q.len == '0) begin
            set[sdev_pkg::FLG_TRN] = 1'b1;
            d.st = sdev_pkg::ST_PROG;
          end else begin
            d.cnt = q.len;
            d.st  = sdev_pkg::ST_XFER;
          end
        end
      end
      sdev_pkg::ST_XFER: begin
        if (cmd_wr) begin
          d.hold_bsy = w[sdev_pkg::CMD_BSY_BIT];
          d.st       = sdev_pkg::ST_HOLD;
        end else if (i_evt.byte_moved) begin
          d.cnt = q.cnt - 1'b1;
          if (q.cnt == LEN_W'(1)) begin
            set[sdev_pkg::FLG_TRN] = 1'b1;
            d.st = sdev_pkg::ST_PROG;
          end
        end
      end
      sdev_pkg::ST_HOLD: begin
        // Only a busy-expected command ends the block early
        if (i_evt.cmd_end) begin
          d.st = q.hold_bsy ? sdev_pkg::ST_IDLE : sdev_pkg::ST_XFER;
        end
      end
      sdev_pkg::ST_PROG: begin
        if (i_evt.crc_prog_done) begin
          set[sdev_pkg::FLG_DAT] = 1'b1;
          d.st = sdev_pkg::ST_IDLE;
        end
      end
    endcase

    // Busy watch starts when a busy-expected command completes
    if (i_evt.cmd_end && q.bexp) begin
      d.bexp  = 1'b0;
      d.bw    = 1'b1;
      d.bseen = 1'b0;
      d.bcnt  = '0;
    end else if (q.bw && clk_rise) begin
      if (!pin_s[2]) begin
        d.bseen = 1'b1;
      end else if (q.bseen || q.bcnt == BUSY_WAIT - 8'h01) begin
        set[sdev_pkg::FLG_BSY] = 1'b1;
        d.bw = 1'b0;
      end else begin
        d.bcnt = q.bcnt + 8'h01;
      end
    end

    if (q.dp_rst) begin
      d.st = sdev_pkg::ST_IDLE;
      d.cnt = '0;
      d.bw = 1'b0;
    end

    // Card detect
    if ((q.edge_sel[0] && pin_s[1] && !q.prev_dat3) ||
        (q.edge_sel[1] && !pin_s[1] && q.prev_dat3)) begin
      set[sdev_pkg::FLG_EDGE] = 1'b1;
    end

    set[sdev_pkg::FLG_RSP]  = i_evt.rsp_ok | i_evt.no_rsp_sent;
    set[sdev_pkg::FLG_RCRC] = i_evt.rsp_crc;
    set[sdev_pkg::FLG_DCRC] = i_evt.rd_crc;
    set[sdev_pkg::FLG_WCRC] = i_evt.wr_crc;
    set[sdev_pkg::FLG_RTO]  = i_evt.rsp_to;
    set[sdev_pkg::FLG_DTO]  = i_evt.rd_to;

    if (i_evt.rx_valid) begin
      d.rxd = i_rx_word;
      set[sdev_pkg::FLG_RX] = 1'b1;
    end
    clr[sdev_pkg::FLG_RX] = q.dp_rst | data_clear_on_command |
                            (rd_fin & (i_avs_address == sdev_pkg::ADDR_RXD));

    set[sdev_pkg::FLG_TX] = q.dp_rst | data_clear_on_command | i_evt.tx_sent |
                            (wr_fin & (i_avs_address == sdev_pkg::ADDR_TXD));
    clr[sdev_pkg::FLG_TX] = i_evt.tx_load;

    // Only bits already returned are cleared, so a fresh event is never lost
    if (rd_fin && i_avs_address == sdev_pkg::ADDR_STAT) begin
      clr = clr | (q.rdata[sdev_pkg::FLAGS_W-1:0] & sdev_pkg::FLAGS_COR);
    end

    d.flags = ((q.flags & ~clr) | set) & sdev_pkg::FLAGS_IMPL;
    if (d.st != sdev_pkg::ST_IDLE) begin
      d.flags[sdev_pkg::FLG_DAT] = 1'b0;
    end
    d.irq = |(d.flags & ~q.flags & q.mask);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      q           <= '0;
      q.st        <= sdev_pkg::ST_IDLE;
      q.flags     <= sdev_pkg::FLAGS_RST;
      q.mask      <= sdev_pkg::MASK_RST;
      q.dp_rst    <= sdev_pkg::CTL_DPRST_RST;
      q.edge_sel  <= sdev_pkg::CTL_EDGE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_avs_waitrequest = req & ~q.ack;
  assign o_avs_readdata    = q.rdata;
  assign o_tx_word         = q.txd;
  assign o_cmd_start       = q.cmd_start;
  assign o_cmd_bits        = q.cmdw;
  assign o_status          = {19'h0, q.flags};
  assign o_irq_req         = q.irq;
  // One driver for the whole carrier
  assign o_dp              = '{active:     q.st != sdev_pkg::ST_IDLE,
                               pause:      q.st == sdev_pkg::ST_HOLD,
                               in_reset:   q.dp_rst,
                               busy_watch: q.bw};
endmodule

// file: tb/sdev_status_properties.sv
// Purpose: Concurrent checks of the status flag bank at its ports
// Assumes: One clock domain, synchronous active-high reset
// Notes: Pin-driven flags (bits 11, 1) are left out of the clear checks
`timescale 1ns/1ps
module sdev_status_properties (
  input wire logic                i_mclk,
  input wire logic                i_srst,
  input wire logic [7:0]          i_avs_address,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire logic [31:0]         o_avs_readdata,
  input wire logic                o_avs_waitrequest,
  input wire sdev_pkg::sdev_evt_t i_evt,
  input wire sdev_pkg::sdev_dp_t  o_dp,
  input wire logic [31:0]         o_status
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence stat_rd_s;
    i_avs_read && !o_avs_waitrequest && i_avs_address == sdev_pkg::ADDR_STAT && i_evt == '0;
  endsequence
  sequence rxd_rd_s;
    i_avs_read && !o_avs_waitrequest && i_avs_address == sdev_pkg::ADDR_RXD && !i_evt.rx_valid;
  endsequence
  rsp_crc_set_a: assert property (i_evt.rsp_crc |=> o_status[7])
    else $error("response crc flag not set");
  rd_crc_set_a: assert property (i_evt.rd_crc |=> o_status[6])
    else $error("read crc flag not set");
  wr_crc_set_a: assert property (i_evt.wr_crc |=> o_status[5])
    else $error("write crc flag not set");
  rsp_to_set_a: assert property (i_evt.rsp_to |=> o_status[4])
    else $error("response timeout flag not set");
  rd_to_set_a: assert property (i_evt.rd_to |=> o_status[3])
    else $error("read timeout flag not set");
  rsp_done_set_a: assert property (i_evt.rsp_ok || i_evt.no_rsp_sent |=> o_status[2])
    else $error("response done flag not set");
  rx_ready_set_a: assert property (i_evt.rx_valid |=> o_status[10])
    else $error("receive ready not set");
  rx_ready_clr_a: assert property (rxd_rd_s |=> !o_status[10])
    else $error("receive ready not cleared by data read");
  tx_ready_set_a: assert property (i_avs_write && !o_avs_waitrequest &&
    i_avs_address == sdev_pkg::ADDR_TXD |=> o_status[9]) else $error("transmit ready not set");
  read_clears_a: assert property (stat_rd_s |=> (o_status & o_avs_readdata & 32'h10fd) == '0)
    else $error("returned flags not cleared by status read");
  rx_kept_a: assert property (stat_rd_s ##0 o_status[10] |=> o_status[10])
    else $error("receive ready lost on status read");
  reserved_zero_a: assert property (o_status[31:13] == '0 && !o_status[8])
    else $error("reserved status bits not zero");
  done_low_busy_a: assert property (o_dp.active && $past(o_dp.active) |-> !o_status[0])
    else $error("data done high during transfer");
endmodule

bind sdev_status sdev_status_properties i_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_evt(i_evt), .o_dp(o_dp), .o_status(o_status));

// file: tb/sdev_card_model.sv
// Purpose: Memory card side of the busy handshake
// Assumes: Card clock period 64 ns, only inside a busy frame
// Notes: DAT0 has a pull-up, so a released line reads high
`timescale 1ns/1ps
module sdev_card_model (
  output logic o_card_clk,
  output logic o_dat0
);
  initial begin
    o_card_clk = 1'b0;
    o_dat0 = 1'b1;
  end
  // Busy low for the first low clocks of the frame; clock stands still afterwards
  task automatic busy(input int low, input int cyc);
    for (int i = 0; i < cyc; i++) begin
      o_dat0 = (i < low) ? 1'b0 : 1'b1;
      #32 o_card_clk = 1'b1;
      #32 o_card_clk = 1'b0;
    end
    o_dat0 = 1'b1;
  endtask
endmodule

// file: tb/tb_sdev_status.sv
// Purpose: Self-checking bench of the status flag bank against an integer flag model
// Assumes: One wait cycle per access, event pulses on the bus clock
// Notes: Busy wait shortened to 4 card clocks to keep the run short
`timescale 1ns/1ps
module tb_sdev_status;
  logic                clk, srst, rd, wr, card_clk, dat3, dat0, wreq, cst, irq;
  logic [7:0]          adr;
  logic [31:0]         wd, rdat, rxw, rdata, txw, stat, w;
  logic [2:0]          cbits;
  sdev_pkg::sdev_evt_t evt;
  sdev_pkg::sdev_dp_t  dp;
  int                  n_fail, samples_checked, seed, m, k;
  int                  ev[7] = '{12, 11, 9, 8, 7, 6, 5};
  int                  fl[7] = '{2, 2, 7, 6, 5, 4, 3};

  sdev_status #(.BUSY_WAIT(8'h04)) i_sdev_status (
    .i_mclk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_card_clk(card_clk), .i_dat3_pin(dat3), .i_dat0_pin(dat0),
    .i_evt(evt), .i_rx_word(rxw), .o_tx_word(txw), .o_cmd_start(cst), .o_cmd_bits(cbits),
    .o_dp(dp), .o_status(stat), .o_irq_req(irq));
  sdev_card_model i_sdev_card_model (.o_card_clk(card_clk), .o_dat0(dat0));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low; released only after that edge
  task automatic bus(input logic w_, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w_;
    wr <= w_;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0 && ++n < 40);
    if (wreq !== 1'b0) begin
      n_fail++;
      conclude();
    end
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Status read: model keeps only the two ready flags
  task automatic rs();
    rc(sdev_pkg::ADDR_STAT, m);
    m &= 'h600;
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    evt <= sdev_pkg::sdev_evt_t'(13'h1 << b);
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    seed = 6767;
    srst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    evt = '0;
    rxw = 32'h0;
    dat3 = 1'b0;
    m = 'h200;
    wt(3);
    srst <= 1'b0;
    rs();
    rc(8'hfc, 32'h0);
    bus(1'b1, sdev_pkg::ADDR_STAT, $random(seed));
    rs();
    for (k = 0; k < 7; k++) begin
      pulse(ev[k]);
      m |= 1 << fl[k];
      rs();
      rs();
    end
    bus(1'b1, sdev_pkg::ADDR_MASK, 32'h4);
    pulse(12);
    #1;
    chk(32'(irq), 32'h1);
    @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    m |= 'h4;
    rs();
    rxw <= $random(seed);
    pulse(2);
    m |= 'h400;
    rs();
    rc(sdev_pkg::ADDR_RXD, rxw);
    m = 'h200;
    rs();
    pulse(1);
    m = 0;
    rs();
    w = $random(seed);
    bus(1'b1, sdev_pkg::ADDR_TXD, w);
    #1;
    chk(txw, w);
    m = 'h200;
    rs();
    pulse(1);
    pulse(0);
    rs();
    // Both clear paths: command with data clear, then data-path reset
    for (k = 0; k < 2; k++) begin
      pulse(2);
      pulse(1);
      bus(1'b1, k ? sdev_pkg::ADDR_CTL : sdev_pkg::ADDR_CMD, k ? 32'h1 : 32'h4);
      bus(1'b1, sdev_pkg::ADDR_CTL, 32'h0);
      rs();
    end
    bus(1'b1, sdev_pkg::ADDR_LEN, 32'h3);
    bus(1'b1, sdev_pkg::ADDR_CMD, 32'h1);
    #1;
    chk(32'({cst, cbits}), 32'h9);
    wt(3);
    chk(32'(dp), 32'h8);
    pulse(4);
    pulse(4);
    bus(1'b1, sdev_pkg::ADDR_CMD, 32'h0);
    wt(3);
    chk(32'(dp), 32'hc);
    pulse(10);
    wt(2);
    chk(32'(dp), 32'h8);
    pulse(4);
    m |= 'h1000;
    rs();
    pulse(3);
    m |= 1;
    rs();
    bus(1'b1, sdev_pkg::ADDR_CMD, 32'h1);
    pulse(4);
    bus(1'b1, sdev_pkg::ADDR_CMD, 32'h2);
    pulse(10);
    wt(3);
    chk(32'(dp), 32'h1);
    i_sdev_card_model.busy(3, 6);
    wt(8);
    m |= 2;
    rs();
    bus(1'b1, sdev_pkg::ADDR_CMD, 32'h2);
    pulse(10);
    i_sdev_card_model.busy(0, 8);
    wt(8);
    m |= 2;
    rs();
    for (k = 1; k < 4; k++) begin
      bus(1'b1, sdev_pkg::ADDR_CTL, 32'(k << 6));
      dat3 <= 1'b1;
      wt(8);
      m |= (k & 1) << 11;
      rs();
      dat3 <= 1'b0;
      wt(8);
      m |= (k >> 1) << 11;
      rs();
    end
    conclude();
  end

  // Whole sequence needs a few hundred cycles; this bound only catches a hang
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
endmodule
